/* File: design/fesov_defines.vh */
`ifndef FESOV_DEFINES_VH
`define FESOV_DEFINES_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define FESOV_OFF_MODE      8'h00
`define FESOV_OFF_STATUS    8'h04
`define FESOV_OFF_EBLOW     8'h08
`define FESOV_OFF_EBHIGH    8'h0C
`define FESOV_OFF_OVERLAY   8'h10
`define FESOV_OFF_IRQSTAT   8'h14
`define FESOV_OFF_IRQMASK   8'h18

// ****************************************************************
// field positions
// ****************************************************************
`define FESOV_MODE_WEN      7
`define FESOV_MODE_SWE      6
`define FESOV_MODE_ESU      5
`define FESOV_MODE_PSU      4
`define FESOV_MODE_EV       3
`define FESOV_MODE_PV       2
`define FESOV_MODE_E        1
`define FESOV_MODE_P        0
`define FESOV_STAT_ERR      7
`define FESOV_OVL_EN        3
`define FESOV_IRQ_ERR       0
`define FESOV_IRQ_AUTOCLR   1
`define FESOV_IRQ_PIN       2

// ****************************************************************
// reset values and answers
// ****************************************************************
`define FESOV_RST_MODE      7'h00
`define FESOV_RST_EBLOW     8'h00
`define FESOV_RST_EBHIGH    4'h0
`define FESOV_RST_OVERLAY   4'h0
`define FESOV_RST_IRQ       3'h0
`define FESOV_RESP_OKAY     2'h0
`define FESOV_RESP_SLVERR   2'h2

// ****************************************************************
// block address map
// ****************************************************************
`define FESOV_SMALL_SIZE    18'h0_1000
`define FESOV_EB8_BASE      18'h0_8000
`define FESOV_EB9_BASE      18'h1_0000
`define FESOV_ERASE_BLOCK_10_BASE     18'h2_0000
`define FESOV_ERASE_BLOCK_11_BASE     18'h3_0000

`endif

/* File: design/fesov_sync.v */
// ****************************************************************
// two flip-flop synchroniser
// ****************************************************************
module fesov_sync
(
  input  wire clk,
  input  wire rst,
  input  wire asyncIn,
  output wire syncOut
);

  reg stage1_q;
  reg stage2_q;

  always @(posedge clk)
  begin
    if (rst)
    begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end
    else
    begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end

  assign syncOut = stage2_q;

endmodule

/* File: design/fesov_top.v */
// How it works
// - error flag sits at status bit 7, set by a fault during program/erase
// - while the error flag is set, program and erase are blocked
// - reserved bits read as zero; software writes zeros there
// - write protect pin high forces both erase selects to zero
// - software write enable low also holds both erase selects at zero
// - more than one select bit set after a write clears both registers
// - low select bit n picks the 4-kbyte block at n times 0x1000
// - high select bit 0 picks the 32-kbyte block at 0x008000
// - high select bits 1 to 3 pick 64-kbyte blocks up to 0x03FFFF
// - overlay enable maps a flash area onto RAM and protects all blocks
// - overlay enable low lets flash accesses reach the array normally
// - area code n selects the 4-kbyte area at n times 0x1000
// - write enable low refuses setting any control or select bit; write protect pin high alone still lets SWE, EV and PV be set
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`include "fesov_defines.vh"

module fesov_top
#(
  parameter ADDR_W = 8
)
(
  input  wire              clk,
  input  wire              rst,
  input  wire              awvalid,
  output wire              awready,
  input  wire [ADDR_W-1:0] awaddr,
  input  wire              wvalid,
  output wire              wready,
  input  wire [31:0]       wdata,
  input  wire [3:0]        wstrb,
  output wire              bvalid,
  input  wire              bready,
  output wire [1:0]        bresp,
  input  wire              arvalid,
  output wire              arready,
  input  wire [ADDR_W-1:0] araddr,
  output wire              rvalid,
  input  wire              rready,
  output wire [31:0]       rdata,
  output wire [1:0]        rresp,
  input  wire              hardwareWriteProtectPin,
  input  wire              flashFault,
  input  wire [17:0]       flashAddr,
  output wire              irq,
  output wire [5:0]        flashModeBits,
  output wire [11:0]       eraseBlockSel,
  output wire [17:0]       eraseBase,
  output wire              protectAll,
  output wire              overlayEnable,
  output wire [17:0]       overlayBase,
  output wire              overlayHit
);

  // ****************************************************************
  // functions
  // ****************************************************************
  function multiBit;
    input [11:0] v;
    begin
      multiBit = |(v & (v - 12'h001));
    end
  endfunction

  function [17:0] smallBase;
    input [2:0] idx;
    begin
      smallBase = {3'b000, idx, 12'h000};
    end
  endfunction

  function [17:0] blockBase;
    input [11:0] sel;
    integer i;
    begin
      blockBase = 18'h0_0000;
      for (i = 0; i < 8; i = i + 1)
      begin
        if (sel[i])
        begin
          blockBase = smallBase(i[2:0]);
        end
      end
      if (sel[8])
      begin
        blockBase = `FESOV_EB8_BASE;
      end
      if (sel[9])
      begin
        blockBase = `FESOV_EB9_BASE;
      end
      if (sel[10])
      begin
        blockBase = `FESOV_ERASE_BLOCK_10_BASE;
      end
      if (sel[11])
      begin
        blockBase = `FESOV_ERASE_BLOCK_11_BASE;
      end
    end
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  reg              awready_q;
  reg              wready_q;
  reg              bvalid_q;
  reg [1:0]        bresp_q;
  reg              arready_q;
  reg              rvalid_q;
  reg [31:0]       rdata_q;
  reg [1:0]        rresp_q;
  reg [ADDR_W-1:0] wrAddr_q;
  reg [31:0]       wrData_q;
  reg [3:0]        wrStrb_q;
  reg [6:0]        mode_q;
  reg              error_q;
  reg [7:0]        ebLow_q;
  reg [3:0]        ebHigh_q;
  reg [3:0]        overlay_q;
  reg [2:0]        irqStat_q;
  reg [2:0]        irqMask_q;
  reg              irq_q;
  reg              pinPrev_q;
  reg [17:0]       eraseBase_q;
  reg              protect_q;
  reg [17:0]       overlayBase_q;
  reg              overlayHit_q;

  wire pinSync;
  wire awTaken;
  wire wTaken;
  wire doWrite;
  wire arTaken;
  wire weAllowed;
  wire blocked;
  wire errSet;
  wire [7:0] wLo;

  fesov_sync uPinSync
  (
    .clk     (clk),
    .rst     (rst),
    .asyncIn (hardwareWriteProtectPin),
    .syncOut (pinSync)
  );

  assign awTaken   = awvalid & awready_q;
  assign wTaken    = wvalid & wready_q;
  assign doWrite   = ~awready_q & ~wready_q & ~bvalid_q;
  assign arTaken   = arvalid & arready_q;
  assign weAllowed = mode_q[`FESOV_MODE_SWE] & ~pinSync;
  assign blocked   = error_q | overlay_q[`FESOV_OVL_EN] | ~weAllowed;
  assign errSet    = flashFault &
                     (mode_q[`FESOV_MODE_P] | mode_q[`FESOV_MODE_E]);
  assign wLo       = wrStrb_q[0] ? wrData_q[7:0] : 8'h00;

  // ****************************************************************
  // write decode
  // ****************************************************************
  reg        hitWrite;
  reg [6:0]  modeNext;
  reg [11:0] ebNext;
  reg        autoClr;

  always @*
  begin
    hitWrite = 1'b0;
    modeNext = mode_q;
    ebNext   = {ebHigh_q, ebLow_q};
    autoClr  = 1'b0;
    case (wrAddr_q)
      `FESOV_OFF_MODE:
      begin
        hitWrite = 1'b1;
        if (wrStrb_q[0])
        begin
          modeNext = wLo[6:0];
        end
      end
      `FESOV_OFF_STATUS, `FESOV_OFF_OVERLAY,
      `FESOV_OFF_IRQSTAT, `FESOV_OFF_IRQMASK:
      begin
        hitWrite = 1'b1;
      end
      `FESOV_OFF_EBLOW:
      begin
        hitWrite = 1'b1;
        if (wrStrb_q[0])
        begin
          ebNext[7:0] = wLo;
        end
      end
      `FESOV_OFF_EBHIGH:
      begin
        hitWrite = 1'b1;
        if (wrStrb_q[0])
        begin
          ebNext[11:8] = wLo[3:0];
        end
      end
      default:
      begin
        hitWrite = 1'b0;
      end
    endcase
    if (!modeNext[`FESOV_MODE_SWE])
    begin
      modeNext[5:0] = 6'h00;
    end
    if (!modeNext[`FESOV_MODE_ESU])
    begin
      modeNext[`FESOV_MODE_E] = 1'b0;
    end
    if (!modeNext[`FESOV_MODE_PSU])
    begin
      modeNext[`FESOV_MODE_P] = 1'b0;
    end
    if (multiBit(ebNext))
    begin
      ebNext  = 12'h000;
      autoClr = 1'b1;
    end
  end

  // ****************************************************************
  // bus handshakes
  // ****************************************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `FESOV_RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= `FESOV_RESP_OKAY;
      wrAddr_q  <= {ADDR_W{1'b0}};
      wrData_q  <= 32'h0000_0000;
      wrStrb_q  <= 4'h0;
    end
    else
    begin
      if (awTaken)
      begin
        awready_q <= 1'b0;
        wrAddr_q  <= awaddr;
      end
      if (wTaken)
      begin
        wready_q <= 1'b0;
        wrData_q <= wdata;
        wrStrb_q <= wstrb;
      end
      if (doWrite)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= hitWrite ? `FESOV_RESP_OKAY : `FESOV_RESP_SLVERR;
      end
      else if (bvalid_q && bready)
      begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
      if (arTaken)
      begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rresp_q   <= (araddr <= `FESOV_OFF_IRQMASK &&
                      araddr[1:0] == 2'b00) ?
                     `FESOV_RESP_OKAY : `FESOV_RESP_SLVERR;
      end
      else if (rvalid_q && rready)
      begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (arTaken)
    begin
      case (araddr)
        `FESOV_OFF_MODE:    rdata_q <= {24'h00_0000, ~pinSync, mode_q};
        `FESOV_OFF_STATUS:  rdata_q <= {24'h00_0000, error_q, 7'h00};
        `FESOV_OFF_EBLOW:   rdata_q <= {24'h00_0000, ebLow_q};
        `FESOV_OFF_EBHIGH:  rdata_q <= {28'h000_0000, ebHigh_q};
        `FESOV_OFF_OVERLAY: rdata_q <= {28'h000_0000, overlay_q};
        `FESOV_OFF_IRQSTAT: rdata_q <= {29'h0000_0000, irqStat_q};
        `FESOV_OFF_IRQMASK: rdata_q <= {29'h0000_0000, irqMask_q};
        default:            rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      mode_q    <= `FESOV_RST_MODE;
      error_q   <= 1'b0;
      ebLow_q   <= `FESOV_RST_EBLOW;
      ebHigh_q  <= `FESOV_RST_EBHIGH;
      overlay_q <= `FESOV_RST_OVERLAY;
      irqMask_q <= `FESOV_RST_IRQ;
    end
    else
    begin
      if (errSet)
      begin
        error_q <= 1'b1;
      end
      if (doWrite && wrAddr_q == `FESOV_OFF_MODE)
      begin
        mode_q <= modeNext;
      end
      else if (!mode_q[`FESOV_MODE_SWE])
      begin
        mode_q[5:0] <= 6'h00;
      end
      if (blocked || errSet)
      begin
        mode_q[`FESOV_MODE_ESU] <= 1'b0;
        mode_q[`FESOV_MODE_PSU] <= 1'b0;
        mode_q[`FESOV_MODE_E]   <= 1'b0;
        mode_q[`FESOV_MODE_P]   <= 1'b0;
      end
      if (pinSync || !mode_q[`FESOV_MODE_SWE])
      begin
        ebLow_q  <= 8'h00;
        ebHigh_q <= 4'h0;
      end
      else if (doWrite)
      begin
        ebLow_q  <= ebNext[7:0];
        ebHigh_q <= ebNext[11:8];
      end
      if (doWrite && wrStrb_q[0] && wrAddr_q == `FESOV_OFF_OVERLAY)
      begin
        overlay_q <= wLo[3:0];
      end
      if (doWrite && wrStrb_q[0] && wrAddr_q == `FESOV_OFF_IRQMASK)
      begin
        irqMask_q <= wLo[2:0];
      end
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      irqStat_q <= `FESOV_RST_IRQ;
      irq_q     <= 1'b0;
      pinPrev_q <= 1'b0;
    end
    else
    begin
      pinPrev_q <= pinSync;
      // set wins over read clear
      irqStat_q <= ((arTaken && araddr == `FESOV_OFF_IRQSTAT) ?
                    3'h0 : irqStat_q) |
                   {pinSync ^ pinPrev_q,
                    doWrite & autoClr & weAllowed,
                    errSet & ~error_q};
      irq_q <= |(irqStat_q & irqMask_q);
    end
  end

  // ****************************************************************
  // address decode outputs
  // ****************************************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      eraseBase_q   <= 18'h0_0000;
      protect_q     <= 1'b1;
      overlayBase_q <= 18'h0_0000;
      overlayHit_q  <= 1'b0;
    end
    else
    begin
      eraseBase_q   <= blockBase({ebHigh_q, ebLow_q});
      protect_q     <= blocked;
      overlayBase_q <= smallBase(overlay_q[2:0]);
      overlayHit_q  <= overlay_q[`FESOV_OVL_EN] &&
                       flashAddr[17:12] == {3'b000, overlay_q[2:0]};
    end
  end

  assign awready       = awready_q;
  assign wready        = wready_q;
  assign bvalid        = bvalid_q;
  assign bresp         = bresp_q;
  assign arready       = arready_q;
  assign rvalid        = rvalid_q;
  assign rdata         = rdata_q;
  assign rresp         = rresp_q;
  assign irq           = irq_q;
  assign flashModeBits = mode_q[5:0];
  assign eraseBlockSel = {ebHigh_q, ebLow_q};
  assign eraseBase     = eraseBase_q;
  assign protectAll    = protect_q;
  assign overlayEnable = overlay_q[`FESOV_OVL_EN];
  assign overlayBase   = overlayBase_q;
  assign overlayHit    = overlayHit_q;

endmodule

/* File: tb/fesov_chk.sv */
module fesov_chk
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hardwareWriteProtectPin,
  input wire logic        flashFault,
  input wire logic [17:0] flashAddr,
  input wire logic [5:0]  flashModeBits,
  input wire logic [11:0] eraseBlockSel,
  input wire logic [17:0] eraseBase,
  input wire logic        protectAll,
  input wire logic        overlayEnable,
  input wire logic        overlayHit,
  input wire logic        rvalid,
  input wire logic [31:0] rdata
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  function automatic logic [17:0] baseOf(input logic [11:0] s);
    baseOf = 18'h0_0000;
    for (int i = 1; i < 12; i++)
      if (s[i])
        baseOf = (i < 8) ? 18'(i << 12) : (i == 8) ? 18'h0_8000 : 18'((i - 8) << 16);
  endfunction

  sequence pinHeld;
    hardwareWriteProtectPin [*5];
  endsequence
  sequence faultInOp;
    flashFault && flashModeBits[1:0] != 2'h0;
  endsequence

  // ****************************************************************
  // assertions
  // ****************************************************************
  pin_clears_sel_a: assert property (pinHeld |-> eraseBlockSel == 12'h000)
    else $error("erase select not cleared by protect pin");
  one_select_a: assert property ($onehot0(eraseBlockSel))
    else $error("more than one erase block selected");
  base_match_a: assert property (eraseBase == baseOf($past(eraseBlockSel)))
    else $error("erase base does not match selection");
  hit_needs_en_a: assert property (overlayHit |-> $past(overlayEnable) && $past(flashAddr[17:15]) == 3'h0)
    else $error("overlay hit without enable or outside areas");
  overlay_protects_a: assert property (overlayEnable && $past(overlayEnable) |-> protectAll)
    else $error("overlay on but blocks not protected");
  overlay_blocks_a: assert property (overlayEnable |=> flashModeBits[1:0] == 2'h0)
    else $error("program or erase active under overlay");
  fault_protects_a: assert property (faultInOp |-> ##2 (protectAll && (flashModeBits & 6'h33) == 6'h00) [*4])
    else $error("fault did not force error protection");
  reserved_zero_a: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
    else $error("reserved read bits not zero");
endmodule

bind fesov_top fesov_chk u_chk
(
  .clk, .rst, .hardwareWriteProtectPin, .flashFault, .flashAddr, .flashModeBits,
  .eraseBlockSel, .eraseBase, .protectAll, .overlayEnable, .overlayHit,
  .rvalid, .rdata
);

/* File: tb/tb.sv */
`include "fesov_defines.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        hardwareWriteProtectPin, flashFault, protectAll;
  logic        overlayEnable, overlayHit;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [17:0] flashAddr, eraseBase, overlayBase;
  logic [11:0] eraseBlockSel;
  logic [5:0]  flashModeBits;
  int          miscompares, numChecks;

  fesov_top dut
  (
    .clk, .rst, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp, .hardwareWriteProtectPin, .flashFault, .flashAddr, .irq,
    .flashModeBits, .eraseBlockSel, .eraseBase, .protectAll, .overlayEnable,
    .overlayBase, .overlayHit
  );

  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'h0;
      if (wvalid && wready)
        wvalid <= 1'h0;
      if (bready && bvalid)
      begin
        bready <= 1'h0;
        chk("bresp", er, bresp);
      end
    end
    while (awvalid | wvalid | bready);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'h0;
      if (rready && rvalid)
      begin
        rready <= 1'h0;
        chk("rdata", e, rdata);
        chk("rresp", er, rresp);
      end
    end
    while (arvalid | rready);
  endtask

  task automatic settle;
    repeat (3) @(negedge clk);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #800000;
    miscompares++;
    results();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    {rst, awvalid, wvalid, bready, arvalid, rready} <= 6'h20;
    {hardwareWriteProtectPin, flashFault} <= 2'h0;
    {awaddr, araddr, wdata} <= 48'h0000_0000_0000;
    wstrb <= 4'h1;
    flashAddr <= 18'h0_0000;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    rd(`FESOV_OFF_STATUS, 32'h0000_0000);
    rd(`FESOV_OFF_OVERLAY, 32'h0000_0000);
    wr(8'h40, 32'h0000_0001, 2'h2);
    rd(8'h40, 32'h0000_0000, 2'h2);
    wr(`FESOV_OFF_EBLOW, 32'h0000_0001);
    rd(`FESOV_OFF_EBLOW, 32'h0000_0000);
    wr(`FESOV_OFF_MODE, 32'h0000_0011);
    rd(`FESOV_OFF_MODE, 32'h0000_0080);
    $display("test reset and refusal done");
    wr(`FESOV_OFF_MODE, 32'h0000_0040);
    for (int i = 0; i < 12; i++)
    begin
      wr(`FESOV_OFF_EBLOW, 32'h0000_0000);
      wr(`FESOV_OFF_EBHIGH, 32'h0000_0000);
      wr(i < 8 ? `FESOV_OFF_EBLOW : `FESOV_OFF_EBHIGH, 32'h0000_0001 << (i % 8));
      settle();
      chk("select", 32'h0000_0001 << i, eraseBlockSel);
      chk("base", i < 8 ? i << 12 : i == 8 ? 32'h0000_8000 : (i - 8) << 16, eraseBase);
    end
    rd(`FESOV_OFF_EBHIGH, 32'h0000_0008);
    wr(`FESOV_OFF_EBLOW, 32'h0000_0001);
    rd(`FESOV_OFF_EBHIGH, 32'h0000_0000);
    wr(`FESOV_OFF_EBLOW, 32'h0000_0003);
    rd(`FESOV_OFF_EBLOW, 32'h0000_0000);
    chk("irq", 1'h0, irq);
    wr(`FESOV_OFF_IRQMASK, 32'h0000_0002);
    settle();
    chk("irq", 1'h1, irq);
    rd(`FESOV_OFF_IRQSTAT, 32'h0000_0002);
    settle();
    chk("irq", 1'h0, irq);
    $display("test erase select done");
    wr(`FESOV_OFF_EBLOW, 32'h0000_0004);
    @(posedge clk);
    hardwareWriteProtectPin <= 1'h1;
    repeat (6) @(negedge clk);
    chk("select", 12'h000, eraseBlockSel);
    wr(`FESOV_OFF_EBLOW, 32'h0000_0001);
    rd(`FESOV_OFF_EBLOW, 32'h0000_0000);
    rd(`FESOV_OFF_IRQSTAT, 32'h0000_0004);
    @(posedge clk);
    hardwareWriteProtectPin <= 1'h0;
    settle();
    $display("test protect pin done");
    for (int c = 0; c < 8; c++)
    begin
      wr(`FESOV_OFF_OVERLAY, 32'h0000_0008 | c);
      rd(`FESOV_OFF_OVERLAY, 32'h0000_0008 | c);
      flashAddr <= 18'(c << 12) | 18'h0_0ABC;
      settle();
      chk("ovlen", 1'h1, overlayEnable);
      chk("hit", 1'h1, overlayHit);
      chk("area", c << 12, overlayBase);
      chk("protect", 1'h1, protectAll);
      flashAddr <= 18'(((c + 1) % 8) << 12);
      settle();
      chk("hit", 1'h0, overlayHit);
    end
    wr(`FESOV_OFF_MODE, 32'h0000_0051);
    rd(`FESOV_OFF_MODE, 32'h0000_00C0);
    wr(`FESOV_OFF_OVERLAY, 32'h0000_0007);
    flashAddr <= 18'h0_7010;
    settle();
    chk("ovlen", 1'h0, overlayEnable);
    chk("hit", 1'h0, overlayHit);
    $display("test overlay done");
    wr(`FESOV_OFF_MODE, 32'h0000_0051);
    settle();
    chk("mode", 6'h11, flashModeBits);
    chk("protect", 1'h0, protectAll);
    wr(`FESOV_OFF_IRQMASK, 32'h0000_0001);
    flashFault <= 1'h1;
    @(posedge clk);
    flashFault <= 1'h0;
    settle();
    chk("protect", 1'h1, protectAll);
    chk("irq", 1'h1, irq);
    rd(`FESOV_OFF_STATUS, 32'h0000_0080);
    wr(`FESOV_OFF_MODE, 32'h0000_0051);
    rd(`FESOV_OFF_MODE, 32'h0000_00C0);
    @(posedge clk);
    rst <= 1'h1;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    rd(`FESOV_OFF_STATUS, 32'h0000_0000);
    $display("test flash error done");
    results();
  end
endmodule
